// [rtl/mac_client_port.sv]
// host register port and transmit client path with word buffer and serializer
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// word buffer
// ****************************************************************
module tx_word_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [PTR_W:0]   count_q;
  logic             push;
  logic             pop;

  // honest flags straight from the occupancy count
  assign in_ready_o  = (count_q != (PTR_W+1)'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem_q[rd_ptr_q];

  // storage has no reset; only the pointers and the occupancy count carry control state
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
    end
  end

  // occupancy
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      count_q <= '0;
    end else if (push && !pop) begin
      count_q <= count_q + 1'b1;
    end else if (pop && !push) begin
      count_q <= count_q - 1'b1;
    end
  end
endmodule

// ****************************************************************
// top: host port and transmit client path
// ****************************************************************
module mac_client_port #(
  parameter int BUF_DEPTH = mac_port_pkg::TX_BUF_DEPTH
) (
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  output logic             gbit_en_o,
  input  wire logic        hcs_n_i,
  input  wire logic [7:0]  haddr_i,
  input  wire logic [7:0]  hdatain_i,
  input  wire logic        hwrite_n_i,
  input  wire logic        hread_n_i,
  output logic             hready_n_o,
  output logic             hdataout_en_n_o,
  output logic      [7:0]  hdataout_o,
  input  wire logic [15:0] tx_fifodata_i,
  input  wire logic        tx_fifoavail_i,
  input  wire logic        tx_fifoeof_i,
  input  wire logic        tx_fifoempty_i,
  input  wire logic        tx_last_byte_valid_i,
  output logic             tx_macread_o,
  output logic             tx_line_o,
  output logic             tx_line_en_o,
  output logic             txer_o
);

  mac_port_pkg::host_state_e  host_q;
  mac_port_pkg::fetch_state_e fetch_q;
  mac_port_pkg::ser_state_e   ser_q;

  logic [7:0]  ctrl_q;
  logic [7:0]  delay_q;
  logic [7:0]  urun_cnt_q;
  logic        urun_flag_q;
  logic [7:0]  dataout_q;
  logic        gbit_q;
  logic [7:0]  wait_q;
  logic [15:0] shift_q;
  logic [3:0]  bit_q;
  logic [3:0]  last_bit_q;
  logic        wr_hit;
  logic        rd_hit;
  logic        busy;
  logic        urun_event;
  logic        urun_clear;

  mac_port_pkg::tx_word_s buf_in;
  mac_port_pkg::tx_word_s buf_out;
  logic                   buf_in_valid;
  logic                   buf_in_ready;
  logic                   buf_out_valid;
  logic                   buf_out_ready;

  // ****************************************************************
  // host register port
  // ****************************************************************

  // read mux; unmapped addresses answer zero
  function automatic logic [7:0] rd_mux(input logic [7:0] addr);
    logic [7:0] val;
    val = mac_port_pkg::UNMAPPED_VALUE;
    if (addr == mac_port_pkg::REG_CTRL_ADDR) begin
      val = ctrl_q;
    end else if (addr == mac_port_pkg::REG_DELAY_ADDR) begin
      val = delay_q;
    end else if (addr == mac_port_pkg::REG_STATUS_ADDR) begin
      val = '0;
      val[mac_port_pkg::STATUS_BUSY_BIT] = busy;
      val[mac_port_pkg::STATUS_URUN_BIT] = urun_flag_q;
    end else if (addr == mac_port_pkg::REG_URUN_ADDR) begin
      val = urun_cnt_q;
    end
    return val;
  endfunction

  // a transfer starts only from idle, so a held strobe acts once
  assign wr_hit = (host_q == mac_port_pkg::HOST_IDLE) && !hcs_n_i && !hwrite_n_i;
  assign rd_hit = (host_q == mac_port_pkg::HOST_IDLE) && !hcs_n_i && hwrite_n_i
                  && !hread_n_i;

  // transfer sequencer; the host keeps its strobe low until ready
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      host_q <= mac_port_pkg::HOST_IDLE;
    end else begin
      case (host_q)
        mac_port_pkg::HOST_IDLE: begin
          if (wr_hit) begin
            host_q <= mac_port_pkg::HOST_WR_ACK;
          end else if (rd_hit) begin
            host_q <= mac_port_pkg::HOST_RD_ACK;
          end
        end
        mac_port_pkg::HOST_WR_ACK: begin
          if (hwrite_n_i || hcs_n_i) begin
            host_q <= mac_port_pkg::HOST_IDLE;
          end
        end
        mac_port_pkg::HOST_RD_ACK: begin
          if (hread_n_i || hcs_n_i) begin
            host_q <= mac_port_pkg::HOST_IDLE;
          end
        end
        default: host_q <= mac_port_pkg::HOST_IDLE;
      endcase
    end
  end

  // read data is captured on the same edge that enters the read ack state
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      dataout_q <= '0;
    end else if (rd_hit) begin
      dataout_q <= rd_mux(haddr_i);
    end
  end

  // ready asserts on the same edge as the store or the capture
  assign hready_n_o      = (host_q == mac_port_pkg::HOST_IDLE);
  assign hdataout_en_n_o = (host_q != mac_port_pkg::HOST_RD_ACK);
  assign hdataout_o      = dataout_q;

  // writable registers
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_q  <= mac_port_pkg::CTRL_RESET;
      delay_q <= mac_port_pkg::DELAY_RESET;
    end else if (wr_hit) begin
      if (haddr_i == mac_port_pkg::REG_CTRL_ADDR) begin
        ctrl_q <= hdatain_i;
      end else if (haddr_i == mac_port_pkg::REG_DELAY_ADDR) begin
        delay_q <= hdatain_i;
      end
    end
  end

  // writing one to the status underrun bit clears it
  assign urun_clear = wr_hit && (haddr_i == mac_port_pkg::REG_STATUS_ADDR)
                      && hdatain_i[mac_port_pkg::STATUS_URUN_BIT];

  // sticky underrun flag; a new underrun beats a clear in the same cycle
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      urun_flag_q <= 1'b0;
    end else if (urun_event) begin
      urun_flag_q <= 1'b1;
    end else if (urun_clear) begin
      urun_flag_q <= 1'b0;
    end
  end

  // underrun counter saturates so software never sees it wrap to zero
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      urun_cnt_q <= '0;
    end else if (wr_hit && haddr_i == mac_port_pkg::REG_URUN_ADDR) begin
      urun_cnt_q <= '0;
    end else if (urun_event && urun_cnt_q != 8'hff) begin
      urun_cnt_q <= urun_cnt_q + 8'h01;
    end
  end

  // legacy indication: low in reset, high from the first edge after
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      gbit_q <= 1'b0;
    end else begin
      gbit_q <= 1'b1;
    end
  end
  assign gbit_en_o = gbit_q;

  // ****************************************************************
  // transmit fetch from the client fifo
  // ****************************************************************

  // read only when the client is not empty and our buffer has room
  assign tx_macread_o = (fetch_q == mac_port_pkg::FETCH_READ) && !tx_fifoempty_i
                        && buf_in_ready;
  assign urun_event   = (fetch_q == mac_port_pkg::FETCH_READ) && tx_fifoempty_i;

  // buffered word; an underrun is carried as an error word ending the frame
  always_comb begin
    buf_in           = '0;
    buf_in.data      = tx_fifodata_i;
    buf_in.eof       = tx_fifoeof_i;
    buf_in.two_bytes = tx_last_byte_valid_i;
    buf_in.err       = 1'b0;
    if (fetch_q == mac_port_pkg::FETCH_ERR) begin
      buf_in.data = '0;
      buf_in.eof  = 1'b1;
      buf_in.err  = 1'b1;
    end
  end
  assign buf_in_valid = tx_macread_o || (fetch_q == mac_port_pkg::FETCH_ERR);

  // frame fetch sequencer
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      fetch_q <= mac_port_pkg::FETCH_IDLE;
      wait_q  <= '0;
    end else begin
      case (fetch_q)
        mac_port_pkg::FETCH_IDLE: begin
          if (ctrl_q[mac_port_pkg::CTRL_TXEN_BIT] && tx_fifoavail_i
              && !tx_fifoempty_i) begin
            fetch_q <= mac_port_pkg::FETCH_DELAY;
            wait_q  <= delay_q;
          end
        end
        mac_port_pkg::FETCH_DELAY: begin
          if (wait_q == 8'h00) begin
            fetch_q <= mac_port_pkg::FETCH_READ;
          end else begin
            wait_q <= wait_q - 8'h01;
          end
        end
        mac_port_pkg::FETCH_READ: begin
          if (tx_fifoempty_i) begin
            fetch_q <= mac_port_pkg::FETCH_ERR;
          end else if (tx_macread_o && tx_fifoeof_i) begin
            fetch_q <= mac_port_pkg::FETCH_IDLE;
          end
        end
        mac_port_pkg::FETCH_ERR: begin
          if (buf_in_ready) begin
            fetch_q <= mac_port_pkg::FETCH_IDLE;
          end
        end
        default: fetch_q <= mac_port_pkg::FETCH_IDLE;
      endcase
    end
  end

  tx_word_fifo #(
    .WIDTH ($bits(mac_port_pkg::tx_word_s)),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .mclk_i      (mclk_i),
    .reset_i     (reset_i),
    .in_valid_i  (buf_in_valid),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (buf_in),
    .out_valid_o (buf_out_valid),
    .out_ready_i (buf_out_ready),
    .out_data_o  (buf_out)
  );

  // ****************************************************************
  // line serializer
  // ****************************************************************

  // take the next word on the last bit of a data word, so data words run back to back; an error burst returns to idle first
  assign buf_out_ready = (ser_q == mac_port_pkg::SER_IDLE)
                         || (ser_q == mac_port_pkg::SER_SHIFT && bit_q == last_bit_q);

  // serializer sequencer and shifter; line outputs move only on the clock
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ser_q      <= mac_port_pkg::SER_IDLE;
      shift_q    <= '0;
      bit_q      <= '0;
      last_bit_q <= mac_port_pkg::LAST_BIT_TWO_BYTES;
    end else if (buf_out_ready && buf_out_valid) begin
      bit_q <= '0;
      if (buf_out.err) begin
        ser_q      <= mac_port_pkg::SER_ERR;
        shift_q    <= '0;
        last_bit_q <= mac_port_pkg::ERR_BIT_TIMES;
      end else begin
        ser_q   <= mac_port_pkg::SER_SHIFT;
        shift_q <= {buf_out.data[7:0], buf_out.data[15:8]};
        if (buf_out.eof && !buf_out.two_bytes) begin
          last_bit_q <= mac_port_pkg::LAST_BIT_ONE_BYTE;
        end else begin
          last_bit_q <= mac_port_pkg::LAST_BIT_TWO_BYTES;
        end
      end
    end else if (ser_q != mac_port_pkg::SER_IDLE) begin
      if (bit_q == last_bit_q) begin
        ser_q <= mac_port_pkg::SER_IDLE;
      end else begin
        bit_q   <= bit_q + 4'h1;
        shift_q <= {1'b0, shift_q[15:1]};
      end
    end
  end

  // line outputs; all low in reset and idle
  assign tx_line_o    = (ser_q == mac_port_pkg::SER_SHIFT) && shift_q[0];
  assign tx_line_en_o = (ser_q != mac_port_pkg::SER_IDLE);
  assign txer_o       = (ser_q == mac_port_pkg::SER_ERR);
  assign busy         = (fetch_q != mac_port_pkg::FETCH_IDLE)
                        || (ser_q != mac_port_pkg::SER_IDLE) || buf_out_valid;

endmodule

`default_nettype wire

// [rtl/mac_port_pkg.sv]
// constants, carriers and state types shared by the mac client port logic
package mac_port_pkg;

  // ****************************************************************
  // widths and buffer depth
  // ****************************************************************
  localparam int HOST_ADDR_W = 8;
  localparam int HOST_DATA_W = 8;
  localparam int TX_WORD_W   = 16;
  localparam int TX_BUF_DEPTH = 16;

  // ****************************************************************
  // host register map and reset values
  // ****************************************************************
  localparam logic [7:0] REG_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] REG_DELAY_ADDR  = 8'h01;
  localparam logic [7:0] REG_STATUS_ADDR = 8'h02;
  localparam logic [7:0] REG_URUN_ADDR   = 8'h03;
  localparam logic [7:0] CTRL_RESET      = 8'h01;
  localparam logic [7:0] DELAY_RESET     = 8'h04;
  localparam logic [7:0] UNMAPPED_VALUE  = 8'h00;
  localparam int CTRL_TXEN_BIT   = 0;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_URUN_BIT = 1;

  // ****************************************************************
  // serializer bit counts
  // ****************************************************************
  localparam logic [3:0] LAST_BIT_TWO_BYTES = 4'hf;
  localparam logic [3:0] LAST_BIT_ONE_BYTE  = 4'h7;
  localparam logic [3:0] ERR_BIT_TIMES      = 4'h7;

  // one buffered transmit word with its frame marks
  typedef struct packed {
    logic [15:0] data;
    logic        eof;
    logic        two_bytes;
    logic        err;
  } tx_word_s;

  typedef enum {HOST_IDLE, HOST_WR_ACK, HOST_RD_ACK} host_state_e;
  typedef enum {FETCH_IDLE, FETCH_DELAY, FETCH_READ, FETCH_ERR} fetch_state_e;
  typedef enum {SER_IDLE, SER_SHIFT, SER_ERR} ser_state_e;

endpackage

// [test/mac_client_port_monitor.sv]
// assertion checker for the mac client port, bound to its top module
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// checker
// ****************************************************************
module client_port_monitor #(
  parameter int BUF_DEPTH = 16
) (
  input wire logic       mclk_i,
  input wire logic       reset_i,
  input wire logic       gbit_en_o,
  input wire logic       hcs_n_i,
  input wire logic       hwrite_n_i,
  input wire logic       hread_n_i,
  input wire logic       hready_n_o,
  input wire logic       hdataout_en_n_o,
  input wire logic [7:0] hdataout_o,
  input wire logic       tx_fifoempty_i,
  input wire logic       tx_macread_o,
  input wire logic       tx_line_en_o,
  input wire logic       txer_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  // reset is asynchronous, so the idle levels must already show at the first edge
  chk_reset_idle: assert property (disable iff (1'b0)
    reset_i |-> hready_n_o && hdataout_en_n_o && !gbit_en_o && !tx_macread_o && !txer_o)
    else $error("outputs not idle during reset");
  chk_gbit_high: assert property (!$past(reset_i) |-> gbit_en_o)
    else $error("gigabit indication low out of reset");
  chk_write_ack: assert property (
    hready_n_o && !hcs_n_i && !hwrite_n_i |=> !hready_n_o && hdataout_en_n_o)
    else $error("write not acknowledged one cycle after it was taken");
  chk_read_ack: assert property (
    hready_n_o && !hcs_n_i && hwrite_n_i && !hread_n_i |=> !hready_n_o && !hdataout_en_n_o)
    else $error("read not acknowledged with data one cycle after it was taken");
  chk_oe_ready: assert property (!hdataout_en_n_o |-> !hready_n_o)
    else $error("read data enabled outside a read acknowledge");
  chk_data_hold: assert property (
    !hdataout_en_n_o && !$past(hdataout_en_n_o) |-> $stable(hdataout_o))
    else $error("read data moved while enabled");
  chk_ready_drop: assert property (
    !hready_n_o && hwrite_n_i && hread_n_i |=> hready_n_o)
    else $error("ready held after strobes released");
  chk_read_nonempty: assert property (tx_macread_o |-> !tx_fifoempty_i)
    else $error("read request while client fifo empty");
  chk_txer_burst: assert property (
    $rose(txer_o) |-> (txer_o && tx_line_en_o)[*8] ##1 !txer_o)
    else $error("underrun burst not eight clocks");

  // main scenarios reached
  cover property (hready_n_o && !hcs_n_i && !hwrite_n_i);
  cover property (!hdataout_en_n_o);
  cover property ($rose(txer_o));
endmodule

bind mac_client_port client_port_monitor #(.BUF_DEPTH(BUF_DEPTH)) chk (
  .mclk_i(mclk_i), .reset_i(reset_i), .gbit_en_o(gbit_en_o), .hcs_n_i(hcs_n_i),
  .hwrite_n_i(hwrite_n_i), .hread_n_i(hread_n_i), .hready_n_o(hready_n_o),
  .hdataout_en_n_o(hdataout_en_n_o), .hdataout_o(hdataout_o),
  .tx_fifoempty_i(tx_fifoempty_i), .tx_macread_o(tx_macread_o),
  .tx_line_en_o(tx_line_en_o), .txer_o(txer_o));
`default_nettype wire

// [test/tb_top.sv]
// self-checking testbench for the mac client port
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin err_count++; \
  $display("BAD %s expected %h seen %h", nm, exp, got); end end

module tb_top;
  logic        mclk_i = 1'b0;
  logic        reset_i = 1'b0;
  logic        hcs_n_i = 1'b1;
  logic        hwrite_n_i = 1'b1;
  logic        hread_n_i = 1'b1;
  logic [7:0]  haddr_i = 8'h00;
  logic [7:0]  hdatain_i = 8'h00;
  wire  [15:0] fdata;
  wire         favail, feof, fempty, flbv;
  wire  [7:0]  hdataout_o;
  wire         gbit_en_o, hready_n_o, hdataout_en_n_o;
  wire         tx_macread_o, tx_line_o, tx_line_en_o, txer_o;
  int          err_count = 0;
  int          n_tests = 0;
  logic        bits_q[$];

  // ****************************************************************
  // clock, design and client
  // ****************************************************************
  always #10 mclk_i = ~mclk_i;

  mac_client_port dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .gbit_en_o(gbit_en_o), .hcs_n_i(hcs_n_i),
    .haddr_i(haddr_i), .hdatain_i(hdatain_i), .hwrite_n_i(hwrite_n_i),
    .hread_n_i(hread_n_i), .hready_n_o(hready_n_o), .hdataout_en_n_o(hdataout_en_n_o),
    .hdataout_o(hdataout_o), .tx_fifodata_i(fdata), .tx_fifoavail_i(favail),
    .tx_fifoeof_i(feof), .tx_fifoempty_i(fempty), .tx_last_byte_valid_i(flbv),
    .tx_macread_o(tx_macread_o), .tx_line_o(tx_line_o), .tx_line_en_o(tx_line_en_o),
    .txer_o(txer_o));

  tx_client_model cli (
    .mclk_i(mclk_i), .macread_i(tx_macread_o), .data_o(fdata), .avail_o(favail),
    .eof_o(feof), .empty_o(fempty), .lbv_o(flbv));

  // line bits of data words only; the error burst is judged apart
  always @(posedge mclk_i) begin
    if (tx_line_en_o === 1'b1 && txer_o !== 1'b1) begin
      bits_q.push_back(tx_line_o);
    end
  end

  // ****************************************************************
  // host transfers
  // ****************************************************************
  // the request stands until ready is sampled low, then is released
  task automatic hxfer(input logic wr, input logic [7:0] a, d, output logic [7:0] q);
    int n;
    n = 0;
    hcs_n_i <= 1'b0;
    haddr_i <= a;
    hdatain_i <= d;
    hwrite_n_i <= !wr;
    hread_n_i <= wr;
    @(posedge mclk_i);
    while (hready_n_o !== 1'b0 && n < 20) begin
      @(posedge mclk_i);
      n++;
    end
    `CHK("ready_delay", 1, n)
    `CHK("data_enable", wr, hdataout_en_n_o)
    q = hdataout_o;
    hcs_n_i <= 1'b1;
    hwrite_n_i <= 1'b1;
    hread_n_i <= 1'b1;
    @(posedge mclk_i);
  endtask

  task automatic hwr(input logic [7:0] a, d);
    logic [7:0] q;
    hxfer(1'b1, a, d, q);
  endtask

  task automatic hrd_chk(input string nm, input logic [7:0] a, exp);
    logic [7:0] q;
    hxfer(1'b0, a, 8'h00, q);
    `CHK(nm, exp, q)
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs();
    hrd_chk("ctrl", mac_port_pkg::REG_CTRL_ADDR, mac_port_pkg::CTRL_RESET);
    hrd_chk("delay", mac_port_pkg::REG_DELAY_ADDR, mac_port_pkg::DELAY_RESET);
    hrd_chk("status", mac_port_pkg::REG_STATUS_ADDR, 8'h00);
    hrd_chk("urun", mac_port_pkg::REG_URUN_ADDR, 8'h00);
    hwr(8'h7e, 8'h5a);
    hrd_chk("unmapped", 8'h7e, mac_port_pkg::UNMAPPED_VALUE);
    hwr(mac_port_pkg::REG_DELAY_ADDR, 8'h02);
    hrd_chk("delay_wr", mac_port_pkg::REG_DELAY_ADDR, 8'h02);
    $display("test regs done");
  endtask

  // long frame so the 16-word buffer fills; last word carries its upper byte only
  task automatic t_frame();
    logic        exp_q[$];
    logic [15:0] w;
    int          n;
    bits_q.delete();
    for (int i = 0; i < 20; i++) begin
      w = 16'h0f1e + 16'(i) * 16'h1357;
      cli.push(w, i == 19, 1'b0);
      for (int b = 8; b < 16; b++) exp_q.push_back(w[b]);
      if (i != 19) for (int b = 0; b < 8; b++) exp_q.push_back(w[b]);
    end
    @(posedge mclk_i);
    cli.avail_q <= 1'b1;
    n = 0;
    while (tx_macread_o !== 1'b1 && n < 60) begin
      @(posedge mclk_i);
      n++;
    end
    // delay register holds 2: sampling edge, three wait edges, then the read
    `CHK("start_delay", 5, n)
    cli.avail_q <= 1'b0;
    n = 0;
    while (bits_q.size() < exp_q.size() && n < 3000) begin
      @(posedge mclk_i);
      n++;
    end
    `CHK("bit_count", exp_q.size(), bits_q.size())
    for (int k = 0; k < exp_q.size() && k < bits_q.size(); k++) begin
      `CHK("line_bit", exp_q[k], bits_q[k])
    end
    hrd_chk("status_ok", mac_port_pkg::REG_STATUS_ADDR, 8'h00);
    $display("test frame done");
  endtask

  // client runs dry in mid-frame: error burst, sticky flag and count
  task automatic t_underrun();
    int n;
    int t;
    cli.push(16'h1234, 1'b0, 1'b1);
    cli.push(16'h5678, 1'b0, 1'b1);
    hwr(mac_port_pkg::REG_CTRL_ADDR, 8'h00);
    cli.avail_q <= 1'b1;
    n = 0;
    t = 0;
    // with transmit disabled nothing may be fetched
    repeat (20) begin
      @(posedge mclk_i);
      if (tx_macread_o !== 1'b0) n++;
    end
    `CHK("tx_disabled", 0, n)
    hwr(mac_port_pkg::REG_CTRL_ADDR, mac_port_pkg::CTRL_RESET);
    n = 0;
    while (tx_macread_o !== 1'b1 && n < 60) begin
      @(posedge mclk_i);
      n++;
    end
    cli.avail_q <= 1'b0;
    for (n = 0; n < 300; n++) begin
      @(posedge mclk_i);
      if (txer_o === 1'b1) t++;
    end
    `CHK("txer_len", 8, t)
    hrd_chk("status_urun", mac_port_pkg::REG_STATUS_ADDR, 8'h02);
    hrd_chk("urun_count", mac_port_pkg::REG_URUN_ADDR, 8'h01);
    hwr(mac_port_pkg::REG_STATUS_ADDR, 8'h02);
    hrd_chk("status_clr", mac_port_pkg::REG_STATUS_ADDR, 8'h00);
    hwr(mac_port_pkg::REG_URUN_ADDR, 8'h00);
    hrd_chk("urun_clr", mac_port_pkg::REG_URUN_ADDR, 8'h00);
    $display("test underrun done");
  endtask

  // ****************************************************************
  // run control
  // ****************************************************************
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // the tests need under a thousand cycles; twenty thousand means a hang
  initial begin
    #400000;
    err_count++;
    $display("BAD watchdog expected finish seen hang");
    print_verdict();
  end

  initial begin
    reset_i <= 1'b1; // a real edge, so the async reset takes hold at time zero
    repeat (10) @(posedge mclk_i);
    `CHK("rst_ready", 1'b1, hready_n_o)
    `CHK("rst_oe", 1'b1, hdataout_en_n_o)
    `CHK("rst_gbit", 1'b0, gbit_en_o)
    `CHK("rst_line", 1'b0, tx_line_en_o)
    repeat (10) @(posedge mclk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    `CHK("gbit", 1'b1, gbit_en_o)
    $display("test reset done");
    t_regs();
    t_frame();
    t_underrun();
    print_verdict();
  end
endmodule
`default_nettype wire

// [test/tx_client_model.sv]
// behavioural client transmit fifo, show-ahead, facing the port
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// client fifo model
// ****************************************************************
module tx_client_model (
  input  wire logic        mclk_i,
  input  wire logic        macread_i,
  output logic      [15:0] data_o,
  output logic             avail_o,
  output logic             eof_o,
  output logic             empty_o,
  output logic             lbv_o
);
  logic [17:0] q[$];
  logic        avail_q;

  // words are queued by the bench; a frame mark travels with its word
  task automatic push(input logic [15:0] d, input logic eof, input logic lbv);
    q.push_back({lbv, eof, d});
  endtask

  assign avail_o = avail_q;

  // outputs move only just after the word clock edge
  initial begin
    avail_q = 1'b0;
    data_o = 16'h0000;
    eof_o = 1'b0;
    empty_o = 1'b1;
    lbv_o = 1'b0;
  end

  // pop on a read, then show the new head; an empty fifo scrambles its bus
  always @(posedge mclk_i) begin
    if (macread_i === 1'b1 && q.size() != 0) begin
      void'(q.pop_front());
    end
    if (q.size() != 0) begin
      {lbv_o, eof_o, data_o} <= q[0];
      empty_o <= 1'b0;
    end else begin
      data_o <= ~data_o;
      eof_o <= 1'b0;
      lbv_o <= 1'b0;
      empty_o <= (q.size() == 0);
    end
  end
endmodule
`default_nettype wire
